//--- inc/fifo_ctrl_pkg.sv
// Purpose: constants and types shared by the queue controller
// Assumes: one clock pclk at 200 MHz, APB slave with 32-bit data
// Notes: offsets are byte addresses of aligned words
package fifo_ctrl_pkg;
  localparam int DATA_W = 32;
  localparam int ADDR_W = 12;
  // register offsets
  localparam logic [11:0] OFF_CTRL = 12'h000;
  localparam logic [11:0] OFF_WDATA = 12'h004;
  localparam logic [11:0] OFF_RCMD = 12'h008;
  localparam logic [11:0] OFF_STATUS = 12'h00C;
  localparam logic [11:0] OFF_RDATA = 12'h010;
  // control fields
  localparam int CTRL_CLEAR_BIT = 0;
  localparam int CTRL_ACLR_BIT = 1;
  localparam logic CTRL_ACLR_RESET = 1'b0;
  // status fields
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_READY_BIT = 1;
  localparam int ST_FULL_BIT = 2;
  localparam int ST_PROT_BIT = 3;
  localparam int ST_EMPTY_BIT = 4;
  localparam int ST_RXV_BIT = 5;
  localparam int ST_PEND_BIT = 6;
  localparam int ST_DROP_BIT = 7;
  // clear sequence counts in pclk cycles
  localparam logic [5:0] WARMUP_CYCLES = 6'h08;
  localparam logic [5:0] ACLR_CYCLES = 6'h02;
  localparam logic [5:0] SCLR_CYCLES = 6'h22;
  localparam logic [5:0] SETTLE_CYCLES = 6'h09;
  // read wait parts: queue latency per storage type, then sync stages and margin
  localparam logic [3:0] LAT_LOGIC = 4'h5;
  localparam logic [3:0] LAT_BLOCK = 4'h6;
  localparam logic [3:0] SYNC_STAGES = 4'h2;
  localparam logic [3:0] READ_MARGIN = 4'h2;
  typedef enum logic [1:0] {ST_WARMUP, ST_CLEAR, ST_SETTLE, ST_RUN} seq_t;
endpackage : fifo_ctrl_pkg

//--- hw/fifo_ctrl.sv
// Purpose: controller driving a dual_clock_queue used in single-clock mode
// Assumes: queue clocks both tied to pclk, single_clock_select = 1
// Notes: one read in flight at a time, so no received word is ever lost
`timescale 1ns/1ps
module fifo_ctrl
  import fifo_ctrl_pkg::*;
#(
  parameter bit storage_type_select = 1'b0
)
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  output logic [DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // queue clears
  output logic w_aclr,
  output logic r_aclr,
  output logic w_sclr,
  output logic r_sclr,
  // queue write side
  output logic w_req,
  output logic [DATA_W-1:0] w_data,
  input wire logic w_full,
  input wire logic w_ready,
  // queue read side
  output logic r_req,
  input wire logic [DATA_W-1:0] r_data,
  input wire logic r_valid,
  input wire logic r_empty
);

  localparam logic [3:0] READ_WAIT =
    (storage_type_select ? LAT_BLOCK : LAT_LOGIC) + SYNC_STAGES + READ_MARGIN;

  typedef struct packed {
    seq_t st;
    logic [5:0] cnt;
    logic use_aclr;
    logic aclr;
    logic sclr;
    logic wr;
    logic [DATA_W-1:0] wdat;
    logic rd;
    logic pend;
    logic [3:0] rcnt;
    logic [DATA_W-1:0] rx_data;
    logic rx_valid;
    logic drop;
    logic [DATA_W-1:0] rdata;
    logic err;
  } state_t;

  state_t state_reg;
  state_t state_next;

  logic setup;
  logic access;
  logic running;
  logic can_write;
  logic [DATA_W-1:0] status_word;

  // queue outputs through two flip-flops; single clock, no pointer crossing here
  logic full_seen;
  logic writable_seen;
  logic empty_seen;
  logic valid_seen;
  logic [DATA_W-1:0] data_seen;

  pin_sync #(
    .WIDTH(1)
  ) full_sync_u (
    .pclk(pclk),
    .presetn(presetn),
    .din(w_full),
    .dout(full_seen)
  );

  pin_sync #(
    .WIDTH(1)
  ) protect_sync_u (
    .pclk(pclk),
    .presetn(presetn),
    .din(w_ready),
    .dout(writable_seen)
  );

  pin_sync #(
    .WIDTH(1)
  ) empty_sync_u (
    .pclk(pclk),
    .presetn(presetn),
    .din(r_empty),
    .dout(empty_seen)
  );

  pin_sync #(
    .WIDTH(1)
  ) valid_sync_u (
    .pclk(pclk),
    .presetn(presetn),
    .din(r_valid),
    .dout(valid_seen)
  );

  pin_sync #(
    .WIDTH(DATA_W)
  ) data_sync_u (
    .pclk(pclk),
    .presetn(presetn),
    .din(r_data),
    .dout(data_seen)
  );

  always_comb
  begin
    setup = psel && !penable;
    access = psel && penable;
    running = state_reg.st == ST_RUN;
    can_write = running && !full_seen && writable_seen;
    status_word = '0;
    status_word[ST_BUSY_BIT] = !running;
    status_word[ST_READY_BIT] = running;
    status_word[ST_FULL_BIT] = running && full_seen;
    status_word[ST_PROT_BIT] = running && !writable_seen;
    status_word[ST_EMPTY_BIT] = running && empty_seen;
    status_word[ST_RXV_BIT] = state_reg.rx_valid;
    status_word[ST_PEND_BIT] = state_reg.pend;
    status_word[ST_DROP_BIT] = state_reg.drop;

    state_next = state_reg;
    state_next.wr = 1'b0;
    state_next.rd = 1'b0;

    // clear sequence
    unique case (state_reg.st)
      ST_WARMUP:
      begin
        state_next.aclr = state_reg.use_aclr;
        state_next.sclr = 1'b1;
        state_next.cnt = state_reg.cnt + 6'h01;
        if (state_reg.cnt >= WARMUP_CYCLES)
        begin
          state_next.st = ST_CLEAR;
          state_next.cnt = '0;
        end
      end
      ST_CLEAR:
      begin
        state_next.cnt = state_reg.cnt + 6'h01;
        if (state_reg.cnt >= ACLR_CYCLES)
          state_next.aclr = 1'b0;
        if (state_reg.cnt >= SCLR_CYCLES)
        begin
          state_next.sclr = 1'b0;
          state_next.st = ST_SETTLE;
          state_next.cnt = '0;
        end
      end
      ST_SETTLE:
      begin
        state_next.cnt = state_reg.cnt + 6'h01;
        if (state_reg.cnt >= SETTLE_CYCLES)
        begin
          state_next.st = ST_RUN;
          state_next.cnt = '0;
        end
      end
      ST_RUN:
      begin
        state_next.cnt = '0;
      end
    endcase

    // read in flight: wait for valid or for the latency window to close
    if (state_reg.pend)
    begin
      state_next.rcnt = state_reg.rcnt + 4'h1;
      if (valid_seen)
      begin
        state_next.rx_data = data_seen;
        state_next.rx_valid = 1'b1;
        state_next.pend = 1'b0;
      end
      else if (state_reg.rcnt >= READ_WAIT)
      begin
        state_next.pend = 1'b0;
      end
    end

    // apb
    if (setup)
    begin
      state_next.err = 1'b0;
      state_next.rdata = '0;
      unique case (paddr)
        OFF_CTRL:
          state_next.rdata[CTRL_ACLR_BIT] = state_reg.use_aclr;
        OFF_STATUS:
          state_next.rdata = status_word;
        OFF_RDATA:
          state_next.rdata = state_reg.rx_data;
        OFF_WDATA, OFF_RCMD:
          state_next.rdata = '0;
        default:
          state_next.err = 1'b1;
      endcase
    end
    if (access && !state_reg.err)
    begin
      if (pwrite)
      begin
        unique case (paddr)
          OFF_CTRL:
          begin
            state_next.use_aclr = pwdata[CTRL_ACLR_BIT];
            if (pwdata[CTRL_CLEAR_BIT])
            begin
              state_next.st = ST_WARMUP;
              state_next.cnt = '0;
              state_next.pend = 1'b0;
              state_next.rx_valid = 1'b0;
            end
          end
          OFF_WDATA:
          begin
            if (can_write)
            begin
              state_next.wr = 1'b1;
              state_next.wdat = pwdata;
            end
            else
              state_next.drop = 1'b1;
          end
          OFF_RCMD:
          begin
            if (running && !state_reg.pend && !state_reg.rx_valid)
            begin
              state_next.rd = 1'b1;
              state_next.pend = 1'b1;
              state_next.rcnt = '0;
            end
          end
          OFF_STATUS:
          begin
            if (pwdata[ST_DROP_BIT])
              state_next.drop = 1'b0;
          end
          default:
          begin
            state_next.drop = state_reg.drop;
          end
        endcase
      end
      else if (paddr == OFF_RDATA && !(state_reg.pend && valid_seen))
        state_next.rx_valid = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_reg <= '0;
      state_reg.st <= ST_WARMUP;
      state_reg.use_aclr <= CTRL_ACLR_RESET;
      state_reg.sclr <= 1'b1;
    end
    else
      state_reg <= state_next;
  end

  assign prdata = state_reg.rdata;
  assign pready = 1'b1;
  assign pslverr = access && state_reg.err;
  assign w_aclr = state_reg.aclr;
  assign r_aclr = state_reg.aclr;
  assign w_sclr = state_reg.sclr;
  assign r_sclr = state_reg.sclr;
  assign w_req = state_reg.wr;
  assign w_data = state_reg.wdat;
  assign r_req = state_reg.rd;

endmodule : fifo_ctrl

// two-stage register for one queue output
module pin_sync
  import fifo_ctrl_pkg::*;
#(
  parameter int WIDTH = 1
)
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // data
  input wire logic [WIDTH-1:0] din,
  output logic [WIDTH-1:0] dout
);

  typedef struct packed {
    logic [WIDTH-1:0] first;
    logic [WIDTH-1:0] second;
  } sync_t;

  sync_t sync_reg;
  sync_t sync_next;

  always_comb
  begin
    sync_next.first = din;
    // only the second stage reads the first
    sync_next.second = sync_reg.first;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      sync_reg <= '0;
    else
      sync_reg <= sync_next;
  end

  assign dout = sync_reg.second;

endmodule : pin_sync

//--- verif/fifo_ctrl_checker.sv
// Purpose: clear and request checks on the controller
// Assumes: one clock pclk, presetn low active
// Notes: counters track clear hold and release gap
`timescale 1ns/1ps
module fifo_ctrl_checker
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // queue side
  input wire logic w_aclr,
  input wire logic r_aclr,
  input wire logic w_sclr,
  input wire logic r_sclr,
  input wire logic w_req,
  input wire logic r_req
);
  typedef struct packed {logic [5:0] hi; logic [3:0] lo;} cnt_t;
  cnt_t st_reg;
  cnt_t st_next;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  always_comb
  begin
    st_next.hi = w_sclr ? st_reg.hi + {5'h00, st_reg.hi != 6'h3f} : 6'h00;
    st_next.lo = w_sclr ? 4'h0 : st_reg.lo + {3'h0, st_reg.lo != 4'hf};
  end
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      st_reg <= '0;
    else
      st_reg <= st_next;
  end
  a_wreq_clear_quiet: assert property (w_sclr |-> !w_req)
    else $error("write during clear");
  a_aclr_pair: assert property (w_aclr == r_aclr)
    else $error("async clears differ");
  a_sclr_pair: assert property (w_sclr == r_sclr)
    else $error("sync clears differ");
  a_aclr_in_sclr: assert property (w_aclr |-> w_sclr)
    else $error("async clear alone");
  a_aclr_first: assert property ($fell(w_aclr) |-> w_sclr [*3])
    else $error("sync clear left early");
  a_sclr_hold: assert property ($fell(w_sclr) |-> st_reg.hi >= 6'h20)
    else $error("sync clear too short");
  a_write_gap: assert property (w_req |-> st_reg.lo >= 4'h8)
    else $error("write too soon");
  a_read_single: assert property (r_req |=> !r_req [*8])
    else $error("read while in flight");
endmodule : fifo_ctrl_checker

bind fifo_ctrl fifo_ctrl_checker chk_u (.pclk, .presetn, .w_aclr, .r_aclr, .w_sclr,
  .r_sclr, .w_req, .r_req);

//--- verif/queue_model.sv
// Purpose: behavioural queue on the far side
// Assumes: single clock mode
// Notes: small depth so protect comes early
`timescale 1ns/1ps
module queue_model
  import fifo_ctrl_pkg::*;
#(
  parameter int LAT = 5,
  parameter int DEPTH = 8,
  parameter bit USE_ACLR = 1'b1
)
(
  // clock and clears
  input wire logic clk,
  input wire logic w_aclr,
  input wire logic r_aclr,
  input wire logic w_sclr,
  input wire logic r_sclr,
  // write side
  input wire logic w_req,
  input wire logic [DATA_W-1:0] w_data,
  output logic w_full,
  output logic w_ready,
  // read side
  input wire logic r_req,
  output logic [DATA_W-1:0] r_data,
  output logic r_valid,
  output logic r_empty
);
  logic [DATA_W-1:0] q[$];
  logic [DATA_W-1:0] dp[LAT];
  logic [LAT-1:0] vp;
  wire logic ac = USE_ACLR & (w_aclr | r_aclr);
  // one clock drives both sides, no crossing
  always @(posedge clk or posedge ac)
  begin
    if (ac || w_sclr || r_sclr)
    begin
      q.delete();
      vp <= '0;
      w_full <= 1'b0;
      w_ready <= 1'b1;
      r_empty <= 1'b1;
    end
    else
    begin
      dp[0] <= q.size() > 0 ? q[0] : ~dp[0];
      vp <= {vp[LAT-2:0], r_req && q.size() > 0};
      for (int i = 1; i < LAT; i++)
        dp[i] <= dp[i-1];
      if (r_req && q.size() > 0)
        q.pop_front();
      if (w_req && !w_full)
        q.push_back(w_data);
      w_full <= q.size() >= DEPTH - 2;
      w_ready <= q.size() < DEPTH - 3;
      r_empty <= q.size() == 0;
    end
  end
  assign r_valid = vp[LAT-1];
  assign r_data = vp[LAT-1] ? dp[LAT-1] : ~dp[LAT-1];
endmodule : queue_model

//--- verif/testbench.sv
// Purpose: drives the controller over APB
// Assumes: storage_type_select 0, queue depth 8
// Notes: status read twice after writes to settle flags
`timescale 1ns/1ps
module testbench;
  import fifo_ctrl_pkg::*;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [DATA_W-1:0] pwdata = '0;
  logic [DATA_W-1:0] prdata, w_data, r_data, rd;
  logic pready, pslverr, w_aclr, r_aclr, w_sclr, r_sclr, w_req, w_full, w_ready;
  logic r_req, r_valid, r_empty, err;
  int n_errors = 0;
  int check_count = 0;
  always #2.5 pclk = ~pclk;
  fifo_ctrl #(.storage_type_select(1'b0)) dut_u (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .w_aclr, .r_aclr, .w_sclr,
    .r_sclr, .w_req, .w_data, .w_full, .w_ready, .r_req, .r_data, .r_valid, .r_empty);
  queue_model #(.LAT(LAT_LOGIC)) q_u (.clk(pclk), .w_aclr, .r_aclr, .w_sclr, .r_sclr,
    .w_req, .w_data, .w_full, .w_ready, .r_req, .r_data, .r_valid, .r_empty);
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    check_count++;
    if (g !== e)
    begin
      n_errors++;
      $display("MISMATCH %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic poll(input int b, input logic v);
    int n;
    n = 0;
    do
    begin
      apb(1'b0, OFF_STATUS, '0);
      n++;
    end
    while (rd[b] !== v && n < 40);
    chk("status poll", v, rd[b]);
  endtask : poll
  task automatic pop(input logic hit, input logic [31:0] e);
    apb(1'b1, OFF_RCMD, '0);
    poll(ST_PEND_BIT, 1'b0);
    chk("word held", hit, rd[ST_RXV_BIT]);
    if (hit)
    begin
      apb(1'b0, OFF_RDATA, '0);
      chk("read word", e, rd);
    end
  endtask : pop
  task automatic fill_drain;
    int n;
    for (n = 0; n < 8; n++)
    begin
      apb(1'b1, OFF_WDATA, 32'hA000_0000 + n);
      apb(1'b0, OFF_STATUS, '0);
      apb(1'b0, OFF_STATUS, '0);
      if (rd[ST_PROT_BIT])
        break;
    end
    chk("words to protect", 5, n + 1);
    chk("full late", 0, rd[ST_FULL_BIT]);
    apb(1'b1, OFF_WDATA, 32'hDEAD_0000);
    poll(ST_DROP_BIT, 1'b1);
    for (int i = 0; i < 5; i++)
      pop(1'b1, 32'hA000_0000 + i);
    pop(1'b0, '0);
    chk("empty", 1, rd[ST_EMPTY_BIT]);
    apb(1'b1, OFF_STATUS, 32'h0000_0080);
    poll(ST_DROP_BIT, 1'b0);
  endtask : fill_drain
  task automatic restart;
    apb(1'b1, OFF_WDATA, 32'h0000_1234);
    poll(ST_EMPTY_BIT, 1'b0);
    apb(1'b1, OFF_CTRL, 32'h0000_0003);
    poll(ST_READY_BIT, 1'b0);
    chk("busy in clear", 1, rd[ST_BUSY_BIT]);
    poll(ST_READY_BIT, 1'b1);
    chk("flushed", 1, rd[ST_EMPTY_BIT]);
    pop(1'b0, '0);
    apb(1'b0, OFF_CTRL, '0);
    chk("aclr enable", 1, rd[CTRL_ACLR_BIT]);
  endtask : restart
  task automatic after_reset;
    poll(ST_READY_BIT, 1'b1);
    chk("empty at run", 1, rd[ST_EMPTY_BIT]);
    apb(1'b0, OFF_CTRL, '0);
    chk("ctrl reset", CTRL_ACLR_RESET, rd[CTRL_ACLR_BIT]);
    apb(1'b0, 12'h014, '0);
    chk("unmapped err", 1, err);
    chk("unmapped data", 0, rd);
  endtask : after_reset
  task automatic end_of_test;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : end_of_test
  initial
  begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    after_reset();
    fill_drain();
    restart();
    end_of_test();
  end
  initial
  begin
    #40us;
    n_errors++;
    end_of_test();
  end
endmodule : testbench
